// *** rtl/dcs_map.vh ***
// register map, field layout and timing constants of the dram scheduler
`ifndef DCS_MAP_VH
`define DCS_MAP_VH
// ****************************************
// apb register offsets (byte addresses)
// ****************************************
`define DCS_REG_CTRL 8'h00
`define DCS_REG_LAT0 8'h04
`define DCS_REG_LAT1 8'h08
`define DCS_REG_ZONE 8'h0C
`define DCS_REG_STAT 8'h10
`define DCS_REG_EFF 8'h14
// ****************************************
// control register fields
// ****************************************
`define DCS_CTRL_EN 0
`define DCS_CTRL_CMD2N 1
`define DCS_CTRL_APHYS1 2
`define DCS_CTRL_POP 5:4
`define DCS_CTRL_RANK2 7:6
`define DCS_CTRL_TECH 9:8
`define DCS_CTRL_RATE 11:10
`define DCS_CTRL_W 12
`define DCS_CTRL_RST 12'h010
// ****************************************
// latency set layout {cwl, trp, trcd, tcl}
// ****************************************
`define DCS_LAT_TCL 4:0
`define DCS_LAT_TRCD 9:5
`define DCS_LAT_TRP 14:10
`define DCS_LAT_CWL 19:15
`define DCS_LAT_TIM 14:0
`define DCS_LAT_W 20
`define DCS_LAT_RST 20'h3A529
`define DCS_FLOOR_D3_1333 20'h3A108
`define DCS_FLOOR_D3_1600 20'h4294A
`define DCS_FLOOR_LP_1333 20'h3B18A
`define DCS_FLOOR_LP_1600 20'h43DEC
`define DCS_BURST_CLK 6'h04
// ****************************************
// address decode
// ****************************************
`define DCS_LINE 31:6
`define DCS_LINE_W 26
`define DCS_ZONE_RST 26'h0000000
`define DCS_LCL_COL 6:0
`define DCS_COL_PAD 3'h0
`define DCS_LCL_BANK 9:7
`define DCS_LCL_RANK 10
`define DCS_LCL_ROW1 25:10
`define DCS_LCL_ROW2 25:11
// ****************************************
// dram commands and queue
// ****************************************
`define DCS_CMD_ACT 2'h0
`define DCS_CMD_RD 2'h1
`define DCS_CMD_WR 2'h2
`define DCS_CMD_PRE 2'h3
`define DCS_QDEPTH 4
`define DCS_NBANK 32
`endif

// *** rtl/dcs_bank_timer.v ***
// per-bank countdown that holds off the next command to one dram bank
`timescale 1ns/1ns
module dcs_bank_timer (
   mclk,
   rst_n,
   ce,
   load,
   load_val,
   ready
);
   input wire mclk;
   input wire rst_n;
   input wire ce;
   input wire load; // command issued to this bank
   input wire [5:0] load_val; // cycles to wait, minus one
   output wire ready; // bank may take a command

   reg [5:0] cnt_r; // remaining hold-off cycles

   // ****************************************
   // countdown
   // ****************************************
   // load wins over counting so a fresh command always restarts the wait
   always @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= 6'h00;
      end else if (ce) begin
         if (load) begin
            cnt_r <= load_val;
         end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
         end
      end
   end

   assign ready = (cnt_r == 6'h00);
endmodule

// *** rtl/dcs_scheduler.v ***
// dual channel dram command scheduler with apb configuration
`timescale 1ns/1ns
`include "dcs_map.vh"
module dcs_scheduler (
   mclk,
   rst_n,
   ce,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   req_valid,
   req_ready,
   req_write,
   req_addr,
   req_tag,
   cmd_valid,
   cmd_code,
   cmd_rank,
   cmd_bank,
   cmd_row,
   cmd_col,
   cmd_tag
);
   input wire mclk;
   input wire rst_n;
   input wire ce; // low freezes all state
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [7:0] paddr;
   input wire [31:0] pwdata;
   output wire [31:0] prdata;
   output wire pready;
   output wire pslverr;
   input wire req_valid; // cache-line request
   output wire req_ready;
   input wire req_write;
   input wire [31:0] req_addr;
   input wire [3:0] req_tag;
   output wire [1:0] cmd_valid; // one bit per physical channel
   output wire [3:0] cmd_code; // two bits per channel
   output wire [1:0] cmd_rank;
   output wire [5:0] cmd_bank;
   output wire [31:0] cmd_row;
   output wire [19:0] cmd_col;
   output wire [7:0] cmd_tag;

   // ****************************************
   // configuration state
   // ****************************************
   reg [`DCS_CTRL_W-1:0] ctrl_r; // enable, rate, map, population
   reg [`DCS_LAT_W-1:0] lat0_r; // programmed set, physical channel 0
   reg [`DCS_LAT_W-1:0] lat1_r; // programmed set, physical channel 1
   reg [`DCS_LINE_W-1:0] zone_r; // lines held by logical channel b
   reg [31:0] prdata_r;

   wire en = ctrl_r[`DCS_CTRL_EN];
   wire [1:0] pop = ctrl_r[`DCS_CTRL_POP];
   wire [1:0] tech = ctrl_r[`DCS_CTRL_TECH]; // 1 = lpddr3
   wire [1:0] rate = ctrl_r[`DCS_CTRL_RATE]; // 1 = 1600
   wire [1:0] rank2 = ctrl_r[`DCS_CTRL_RANK2];
   wire dual = (pop == 2'h3);

   // ****************************************
   // latency helpers
   // ****************************************
   function [4:0] max5;
      input [4:0] a;
      input [4:0] b;
      begin
         max5 = (a > b) ? a : b;
      end
   endfunction

   // fieldwise maximum of two sets, every field including cwl
   function [`DCS_LAT_W-1:0] lat_max;
      input [`DCS_LAT_W-1:0] a;
      input [`DCS_LAT_W-1:0] b;
      begin
         lat_max[`DCS_LAT_TCL] = max5(a[`DCS_LAT_TCL], b[`DCS_LAT_TCL]);
         lat_max[`DCS_LAT_TRCD] = max5(a[`DCS_LAT_TRCD], b[`DCS_LAT_TRCD]);
         lat_max[`DCS_LAT_TRP] = max5(a[`DCS_LAT_TRP], b[`DCS_LAT_TRP]);
         lat_max[`DCS_LAT_CWL] = max5(a[`DCS_LAT_CWL], b[`DCS_LAT_CWL]);
      end
   endfunction

   // lowest legal set for one technology at the common rate
   function [`DCS_LAT_W-1:0] lat_floor;
      input lp;
      input fast;
      begin
         if (lp) begin
            lat_floor = fast ? `DCS_FLOOR_LP_1600 : `DCS_FLOOR_LP_1333;
         end else begin
            lat_floor = fast ? `DCS_FLOOR_D3_1600 : `DCS_FLOOR_D3_1333;
         end
      end
   endfunction

   // ****************************************
   // common frequency and latency set
   // ****************************************
   // the slowest populated channel sets the rate for both
   wire eff_rate = dual ? (&rate) : (pop[1] ? rate[1] : rate[0]);
   wire [`DCS_LAT_W-1:0] fl0 = lat_floor(tech[0], eff_rate);
   wire [`DCS_LAT_W-1:0] fl1 = lat_floor(tech[1], eff_rate);
   wire [`DCS_LAT_W-1:0] l0 = lat_max(lat0_r, fl0);
   wire [`DCS_LAT_W-1:0] l1 = lat_max(lat1_r, fl1);
   // cwl is exact per rate, so a programmed value never stretches it
   wire [`DCS_LAT_W-1:0] l0c = {fl0[`DCS_LAT_CWL], l0[`DCS_LAT_TIM]};
   wire [`DCS_LAT_W-1:0] l1c = {fl1[`DCS_LAT_CWL], l1[`DCS_LAT_TIM]};
   wire [`DCS_LAT_W-1:0] eff_lat = dual ? lat_max(l0c, l1c) : (pop[1] ? l1c : l0c);

   // ****************************************
   // address mapping
   // ****************************************
   wire [`DCS_LINE_W-1:0] line = req_addr[`DCS_LINE];
   // interleaved zone covers twice the smaller channel
   wire in_zone = ({1'b0, line} < {zone_r, 1'b0});
   reg map_ch; // physical channel
   reg [`DCS_LINE_W-1:0] lcl; // line within the channel
   reg map_rk;
   reg [15:0] map_row;

   // both zones decode in the same cycle, so mixed traffic needs no mode switch
   always @* begin
      if (!dual) begin
         map_ch = pop[1];
         lcl = line;
      end else if (in_zone) begin
         map_ch = line[0] ^ ctrl_r[`DCS_CTRL_APHYS1];
         lcl = {1'b0, line[`DCS_LINE_W-1:1]};
      end else begin
         map_ch = ctrl_r[`DCS_CTRL_APHYS1];
         lcl = line - zone_r;
      end
      map_rk = rank2[map_ch] & lcl[`DCS_LCL_RANK];
      map_row = rank2[map_ch] ? {1'b0, lcl[`DCS_LCL_ROW2]} : lcl[`DCS_LCL_ROW1];
   end

   // ****************************************
   // request queue
   // ****************************************
   reg [3:0] q_v_r; // slot holds a request
   reg [3:0] q_ch_r;
   reg [3:0] q_rk_r;
   reg [3:0] q_wr_r;
   reg [2:0] q_bk_r [0:3];
   reg [15:0] q_row_r [0:3];
   reg [9:0] q_col_r [0:3];
   reg [3:0] q_tag_r [0:3];
   reg free_v; // some slot is empty
   reg [1:0] free_i;
   integer f;

   // lowest empty slot takes the next request
   always @* begin
      free_v = 1'b0;
      free_i = 2'h0;
      for (f = `DCS_QDEPTH - 1; f >= 0; f = f - 1) begin
         if (!q_v_r[f]) begin
            free_v = 1'b1;
            free_i = f[1:0];
         end
      end
   end

   assign req_ready = en & free_v & ce;
   wire take = req_valid & req_ready;

   // ****************************************
   // bank state and per-channel selection
   // ****************************************
   reg [`DCS_NBANK-1:0] bk_open_r; // row open, per {channel,rank,bank}
   reg [15:0] bk_row_r [0:`DCS_NBANK-1];
   wire [`DCS_NBANK-1:0] tmr_rdy;
   reg [1:0] gap_r; // 2n hold-off per channel
   reg [1:0] sel_v; // channel issues this cycle
   reg [1:0] sel_i [0:1];
   reg [1:0] sel_k [0:1];
   reg [4:0] iss_bi [0:1];
   reg [5:0] tld [0:1];
   reg [1:0] lvl;
   reg [1:0] cur;
   reg [4:0] bi;
   integer c;
   integer i;

   // every pending request is rated at once: row hit, then activate,
   // then precharge; lowest slot breaks ties, so a busy hit stream can
   // delay a conflicting request until the hits drain
   always @* begin
      for (c = 0; c < 2; c = c + 1) begin
         lvl = 2'h0;
         sel_i[c] = 2'h0;
         sel_k[c] = `DCS_CMD_ACT;
         for (i = 0; i < `DCS_QDEPTH; i = i + 1) begin
            bi = {c[0], q_rk_r[i], q_bk_r[i]};
            cur = 2'h0;
            if (q_v_r[i] && (q_ch_r[i] == c[0]) && tmr_rdy[bi]) begin
               if (bk_open_r[bi] && (bk_row_r[bi] == q_row_r[i])) begin
                  cur = 2'h3;
               end else if (!bk_open_r[bi]) begin
                  cur = 2'h2;
               end else begin
                  cur = 2'h1;
               end
            end
            if (cur > lvl) begin
               lvl = cur;
               sel_i[c] = i[1:0];
               case (cur)
                  2'h3: sel_k[c] = q_wr_r[i] ? `DCS_CMD_WR : `DCS_CMD_RD;
                  2'h2: sel_k[c] = `DCS_CMD_ACT;
                  default: sel_k[c] = `DCS_CMD_PRE;
               endcase
            end
         end
         // channels decide independently, so a request on the other
         // channel never waits for this one's data
         sel_v[c] = en && (lvl != 2'h0) && !gap_r[c];
         iss_bi[c] = {c[0], q_rk_r[sel_i[c]], q_bk_r[sel_i[c]]};
         case (sel_k[c])
            `DCS_CMD_ACT: tld[c] = {1'b0, eff_lat[`DCS_LAT_TRCD]} - 6'h01;
            `DCS_CMD_PRE: tld[c] = {1'b0, eff_lat[`DCS_LAT_TRP]} - 6'h01;
            `DCS_CMD_RD: tld[c] = {1'b0, eff_lat[`DCS_LAT_TCL]} + `DCS_BURST_CLK - 6'h01;
            default: tld[c] = {1'b0, eff_lat[`DCS_LAT_CWL]} + `DCS_BURST_CLK - 6'h01;
         endcase
      end
   end

   // ****************************************
   // bank timers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `DCS_NBANK; g = g + 1) begin : g_bank
         localparam [4:0] BI = g;
         dcs_bank_timer u_tmr (
            .mclk(mclk),
            .rst_n(rst_n),
            .ce(ce),
            .load(sel_v[BI[4]] && (iss_bi[BI[4]] == BI)),
            .load_val(tld[BI[4]]),
            .ready(tmr_rdy[g])
         );
      end
   endgenerate

   // ****************************************
   // apb decode
   // ****************************************
   wire mapped = (paddr == `DCS_REG_CTRL) || (paddr == `DCS_REG_LAT0) ||
      (paddr == `DCS_REG_LAT1) || (paddr == `DCS_REG_ZONE) ||
      (paddr == `DCS_REG_STAT) || (paddr == `DCS_REG_EFF);
   wire apb_wr = psel & penable & pwrite & mapped;
   reg [31:0] rd_mux;

   // read data is latched in the setup cycle, so access ends at once
   always @* begin
      case (paddr)
         `DCS_REG_CTRL: rd_mux = {20'h00000, ctrl_r};
         `DCS_REG_LAT0: rd_mux = {12'h000, lat0_r};
         `DCS_REG_LAT1: rd_mux = {12'h000, lat1_r};
         `DCS_REG_ZONE: rd_mux = {6'h00, zone_r};
         `DCS_REG_STAT: rd_mux = {26'h0000000, gap_r, eff_rate, |q_v_r, 2'h0} |
            {24'h000000, q_v_r, 4'h0};
         `DCS_REG_EFF: rd_mux = {12'h000, eff_lat};
         default: rd_mux = 32'h00000000;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_r;

   // ****************************************
   // command outputs
   // ****************************************
   reg [1:0] cmd_v_r;
   reg [3:0] cmd_code_r;
   reg [1:0] cmd_rank_r;
   reg [5:0] cmd_bank_r;
   reg [31:0] cmd_row_r;
   reg [19:0] cmd_col_r;
   reg [7:0] cmd_tag_r;
   integer s;

   // ****************************************
   // main sequential process
   // ****************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r <= `DCS_CTRL_RST;
         lat0_r <= `DCS_LAT_RST;
         lat1_r <= `DCS_LAT_RST;
         zone_r <= `DCS_ZONE_RST;
         prdata_r <= 32'h00000000;
         q_v_r <= 4'h0;
         bk_open_r <= 32'h00000000;
         gap_r <= 2'h0;
         cmd_v_r <= 2'h0;
         cmd_code_r <= 4'h0;
         cmd_rank_r <= 2'h0;
         cmd_bank_r <= 6'h00;
         cmd_row_r <= 32'h00000000;
         cmd_col_r <= 20'h00000;
         cmd_tag_r <= 8'h00;
      end else if (ce) begin
         // register access; only the enable bit moves while traffic runs
         if (psel && !penable) begin
            prdata_r <= rd_mux;
         end
         if (apb_wr && (paddr == `DCS_REG_CTRL)) begin
            if (en) begin
               ctrl_r[`DCS_CTRL_EN] <= pwdata[`DCS_CTRL_EN];
            end else begin
               ctrl_r <= pwdata[`DCS_CTRL_W-1:0];
            end
         end
         if (apb_wr && !en && (paddr == `DCS_REG_LAT0)) begin
            lat0_r <= pwdata[`DCS_LAT_W-1:0];
         end
         if (apb_wr && !en && (paddr == `DCS_REG_LAT1)) begin
            lat1_r <= pwdata[`DCS_LAT_W-1:0];
         end
         if (apb_wr && !en && (paddr == `DCS_REG_ZONE)) begin
            zone_r <= pwdata[`DCS_LINE_W-1:0];
         end
         // new request into an empty slot
         if (take) begin
            q_v_r[free_i] <= 1'b1;
            q_ch_r[free_i] <= map_ch;
            q_rk_r[free_i] <= map_rk;
            q_wr_r[free_i] <= req_write;
            q_bk_r[free_i] <= lcl[`DCS_LCL_BANK];
            q_row_r[free_i] <= map_row;
            q_col_r[free_i] <= {lcl[`DCS_LCL_COL], `DCS_COL_PAD};
            q_tag_r[free_i] <= req_tag;
         end
         // issue per channel; lpddr3 ignores 2n since it takes a command
         // every clock at the controller rate
         for (s = 0; s < 2; s = s + 1) begin
            cmd_v_r[s] <= sel_v[s];
            gap_r[s] <= sel_v[s] & ctrl_r[`DCS_CTRL_CMD2N] & ~tech[s];
            if (sel_v[s]) begin
               cmd_code_r[s*2 +: 2] <= sel_k[s];
               cmd_rank_r[s] <= q_rk_r[sel_i[s]];
               cmd_bank_r[s*3 +: 3] <= q_bk_r[sel_i[s]];
               cmd_row_r[s*16 +: 16] <= q_row_r[sel_i[s]];
               cmd_col_r[s*10 +: 10] <= q_col_r[sel_i[s]];
               cmd_tag_r[s*4 +: 4] <= q_tag_r[sel_i[s]];
               case (sel_k[s])
                  `DCS_CMD_ACT: begin
                     bk_open_r[iss_bi[s]] <= 1'b1;
                     bk_row_r[iss_bi[s]] <= q_row_r[sel_i[s]];
                  end
                  `DCS_CMD_PRE: begin
                     bk_open_r[iss_bi[s]] <= 1'b0;
                  end
                  default: begin
                     q_v_r[sel_i[s]] <= 1'b0; // column command retires
                  end
               endcase
            end
         end
      end
   end

   assign cmd_valid = cmd_v_r;
   assign cmd_code = cmd_code_r;
   assign cmd_rank = cmd_rank_r;
   assign cmd_bank = cmd_bank_r;
   assign cmd_row = cmd_row_r;
   assign cmd_col = cmd_col_r;
   assign cmd_tag = cmd_tag_r;
endmodule

// *** bench/dcs_checker.sv ***
// port-level assertions for the dram scheduler
`timescale 1ns/1ns
module dcs_checker (
   input wire mclk,
   input wire rst_n,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire req_ready,
   input wire [1:0] cmd_valid,
   input wire [3:0] cmd_code,
   input wire [1:0] cmd_rank,
   input wire [5:0] cmd_bank
);
   // ****
   // shadow of the static setup
   // ****
   reg en_r; // traffic enabled
   reg cr2_r; // two clock command rate
   reg lp0_r; // channel 0 holds lpddr3
   reg [1:0] pop_r; // populated channels
   reg [3:0] abank_r; // rank and bank of last channel 0 activate
   reg [3:0] agap_r; // cycles since it, saturating
   wire cfg_wr = psel && penable && pwrite && paddr == 8'h00;
   // the rest of control is locked while enabled, as in the design
   always @(posedge mclk) begin
      if (!rst_n) begin
         en_r <= 1'b0;
         cr2_r <= 1'b0;
         lp0_r <= 1'b0;
         pop_r <= 2'h1;
         agap_r <= 4'hF;
      end else begin
         if (cfg_wr) en_r <= pwdata[0];
         if (cfg_wr && !en_r) cr2_r <= pwdata[1];
         if (cfg_wr && !en_r) lp0_r <= pwdata[8];
         if (cfg_wr && !en_r) pop_r <= pwdata[5:4];
         // only the newest activate is tracked, so the check is one-sided
         if (cmd_valid[0] && cmd_code[1:0] == 2'h0) begin
            abank_r <= {cmd_rank[0], cmd_bank[2:0]};
            agap_r <= 4'h0;
         end else if (agap_r != 4'hF) agap_r <= agap_r + 4'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_rate_two: assert property (en_r && cr2_r && !lp0_r && cmd_valid[0] |=> !cmd_valid[0])
      else $error("two commands too close in 2N mode");
   chk_act_gap: assert property (cmd_valid[0] && (cmd_code[1] ^ cmd_code[0])
      && {cmd_rank[0], cmd_bank[2:0]} == abank_r |-> agap_r >= 4'h7)
      else $error("column command too soon after activate");
   chk_idle_ready: assert property (!en_r |-> !req_ready)
      else $error("request taken while disabled");
   chk_freeze_ready: assert property (!ce |-> !req_ready)
      else $error("request taken while frozen");
   chk_bad_addr: assert property (psel && penable && paddr > 8'h14
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   chk_single_ch: assert property (en_r && pop_r != 2'h3 |-> (cmd_valid & ~pop_r) == 2'h0)
      else $error("command on empty channel");
   chk_quiet_reset: assert property ($rose(rst_n) |-> cmd_valid == 2'h0)
      else $error("command out of reset");
   chk_pready_tie: assert property (psel && penable
      |-> pready && pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h14))
      else $error("access phase stalled or misdecoded");
   cov_both: cover property (cmd_valid == 2'h3);
   cov_two_n: cover property (en_r && cr2_r && cmd_valid[0]);
   cov_lock: cover property (cfg_wr && en_r);
endmodule
bind dcs_scheduler dcs_checker dcs_checker_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_ready(req_ready),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_rank(cmd_rank), .cmd_bank(cmd_bank));

// *** bench/dcs_dram_model.sv ***
// behavioural dram banks on both channels, counting protocol faults
`timescale 1ns/1ns
`include "dcs_map.vh"
module dcs_dram_model (
   input wire mclk,
   input wire rst_n,
   input wire [1:0] cmd_valid,
   input wire [3:0] cmd_code,
   input wire [1:0] cmd_rank,
   input wire [5:0] cmd_bank,
   output int n_bad
);
   // ****
   // bank state by channel, rank, bank
   // ****
   logic open_r [32]; // a row is open
   int t_r [32]; // cycle of last activate or precharge
   int now = 0; // cycle count
   int b; // bank index
   // gaps use the smallest floor, 8, so any legal setting passes
   always @(posedge mclk) begin
      now++;
      if (!rst_n) begin
         n_bad = 0;
         for (int i = 0; i < 32; i++) begin
            open_r[i] = 0;
            t_r[i] = -100;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            b = c * 16 + cmd_rank[c] * 8 + cmd_bank[3*c+:3];
            if (cmd_valid[c] === 1'b1) begin
               case (cmd_code[2*c+:2])
                  `DCS_CMD_ACT: begin
                     if (open_r[b] || now - t_r[b] < 8) n_bad++;
                     open_r[b] = 1;
                     t_r[b] = now;
                  end
                  `DCS_CMD_PRE: begin
                     open_r[b] = 0;
                     t_r[b] = now;
                  end
                  default: if (!open_r[b] || now - t_r[b] < 8) n_bad++;
               endcase
            end
         end
      end
   end
endmodule

// *** bench/dcs_scheduler_tb.sv ***
// self-checking bench: apb setup, latency model, routed traffic
`timescale 1ns/1ns
`include "dcs_map.vh"
module dcs_scheduler_tb;
   // ****
   // stimulus and observed signals
   // ****
   logic mclk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic req_valid = 0, req_write = 0, err;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, req_addr = 0, rd;
   logic [3:0] req_tag = 0;
   logic [19:0] l0, l1; // programmed latency sets
   wire [31:0] prdata, cmd_row;
   wire pready, pslverr, req_ready;
   wire [1:0] cmd_valid, cmd_rank;
   wire [3:0] cmd_code;
   wire [5:0] cmd_bank;
   wire [19:0] cmd_col;
   wire [7:0] cmd_tag;
   int n_errors = 0, comparisons = 0, cyc = 0, seen = 0, dram_bad;
   int pop, swap, zone, ph, loc, t, rk2;
   int e_ph [16], e_bk [16], e_col [16], e_code [16]; // expected per tag
   int e_rk [16], e_row [16]; // expected rank and row per tag
   // {tcl, trcd, trp, cwl} floors, index lpddr3 * 2 + fast rate
   localparam int FL [4][4] = '{'{8, 8, 8, 7}, '{10, 10, 10, 8}, '{10, 12, 12, 7},
      '{12, 15, 15, 8}};
   dcs_scheduler dcs_scheduler_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_tag(req_tag), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
      .cmd_col(cmd_col), .cmd_tag(cmd_tag));
   dcs_dram_model dcs_dram_model_i (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .n_bad(dram_bad));
   initial begin
      forever #10 mclk = ~mclk;
   end
   task chk(input logic [32:0] s, input logic [32:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // a hang is cut short here
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         give_verdict;
      end
   end
   // apb master; result left in rd and err
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // expected channel, bank and column of one cache line
   task expect_line(input int line, input int tg, input logic w);
      if (pop != 3) begin
         ph = (pop == 2);
         loc = line;
      end else if (line < 2 * zone) begin
         ph = (line % 2) ^ swap;
         loc = line / 2;
      end else begin
         ph = swap;
         loc = line - zone;
      end
      e_ph[tg] = ph;
      e_bk[tg] = (loc / 128) % 8;
      e_col[tg] = (loc % 128) * 8;
      // with two ranks the rank bit sits just above the banks
      e_rk[tg] = rk2[ph] ? (loc / 1024) % 2 : 0;
      e_row[tg] = rk2[ph] ? loc / 2048 : loc / 1024;
      e_code[tg] = w ? 2 : 1;
   endtask
   // each column command against the request it answers
   always @(posedge mclk) begin
      for (int c = 0; c < 2; c++) begin
         if (rst_n && cmd_valid[c] === 1'b1 && (cmd_code[2*c+:2] == 1 || cmd_code[2*c+:2] == 2)) begin
            t = cmd_tag[4*c+:4];
            chk(c, e_ph[t]);
            chk(cmd_bank[3*c+:3], e_bk[t]);
            chk(cmd_col[10*c+:10], e_col[t]);
            chk(cmd_rank[c], e_rk[t]);
            chk(cmd_row[16*c+:16], e_row[t]);
            chk(cmd_code[2*c+:2], e_code[t]);
            seen++;
         end
      end
   end
   // per field the slowest of programmed values and floors, except cwl, which comes from the floors alone
   function logic [19:0] eff_exp(input logic [11:0] ctl, input logic [19:0] a, b);
      int r, i0, i1, m;
      r = ctl[11] & ctl[10];
      i0 = ctl[8] * 2 + r;
      i1 = ctl[9] * 2 + r;
      for (int k = 0; k < 4; k++) begin
         m = FL[i0][k] > FL[i1][k] ? FL[i0][k] : FL[i1][k];
         if (k < 3 && a[5*k+:5] > m) m = a[5*k+:5];
         if (k < 3 && b[5*k+:5] > m) m = b[5*k+:5];
         eff_exp[5*k+:5] = m;
      end
   endfunction
   // one batch of sixteen back-to-back requests under a fixed setup
   task run(input logic [11:0] ctl, input int z);
      int base, line;
      logic w;
      pop = ctl[5:4];
      swap = ctl[2];
      rk2 = ctl[7:6];
      zone = z;
      apb(1, `DCS_REG_LAT0, 0);
      apb(1, `DCS_REG_LAT1, 0);
      apb(1, `DCS_REG_ZONE, z);
      apb(1, `DCS_REG_CTRL, ctl);
      apb(1, `DCS_REG_CTRL, ctl | 1);
      apb(1, `DCS_REG_LAT0, 32'hFFFFF);
      apb(0, `DCS_REG_LAT0, 0);
      chk(rd, 0);
      seen = 0;
      base = $urandom % 1024;
      ce <= 0;
      repeat (3) @(posedge mclk);
      ce <= 1;
      for (int i = 0; i < 16; i++) begin
         line = i < 8 ? base + i : $urandom % 4096;
         w = $urandom % 2;
         expect_line(line, i, w);
         req_valid <= 1;
         req_write <= w;
         req_addr <= line * 64;
         req_tag <= i;
         do @(posedge mclk); while (req_ready !== 1'b1);
      end
      req_valid <= 0;
      for (int k = 0; k < 4000 && seen < 16; k++) @(posedge mclk);
      chk(seen, 16);
      chk(dram_bad, 0);
      // idle status shows only the common rate
      apb(0, `DCS_REG_STAT, 0);
      chk(rd, 8 * (pop == 3 ? ctl[11] & ctl[10] : ctl[10 + (pop == 2)]));
      apb(1, `DCS_REG_CTRL, ctl);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h3CFF0BE0));
      repeat (20) @(posedge mclk);
      rst_n <= 1;
      apb(0, `DCS_REG_CTRL, 0);
      chk(rd, `DCS_CTRL_RST);
      apb(0, `DCS_REG_LAT1, 0);
      chk(rd, `DCS_LAT_RST);
      apb(0, `DCS_REG_ZONE, 0);
      chk(rd, 0);
      apb(0, 8'h18, 0);
      chk({err, rd}, 33'h100000000);
      for (int k = 0; k < 16; k++) begin
         l0 = $urandom % 32768;
         l1 = $urandom % 32768;
         apb(1, `DCS_REG_LAT0, l0);
         apb(1, `DCS_REG_LAT1, l1);
         apb(1, `DCS_REG_CTRL, k * 256 + 48);
         apb(0, `DCS_REG_EFF, 0);
         chk(rd, eff_exp(k * 256 + 48, l0, l1));
      end
      run(12'h034, 64);
      run(12'h032, 32'h1000000);
      run(12'hF20, 0);
      run(12'h012, 0);
      give_verdict;
   end
endmodule
